// >>> rtl/cantt_params.svh
// Register offsets, field positions, reset values and reload width of the CAN timer block
`ifndef CANTT_PARAMS_SVH
`define CANTT_PARAMS_SVH
`define CANTT_OFF_RXTO 12'h000
`define CANTT_OFF_TTA 12'h004
`define CANTT_OFF_TTB 12'h008
`define CANTT_OFF_TTC 12'h00c
`define CANTT_OFF_CCR 12'h010
`define CANTT_OFF_IE 12'h014
`define CANTT_OFF_STAT 12'h018
`define CANTT_RELOAD_W 16
`define CANTT_RUN_BIT 31
`define CANTT_TIMEOUT_IRQ_ENABLE_BIT 30
`define CANTT_TE_BIT 29
`define CANTT_IE_FIFO0_NEW_FRAME_IRQ_EN 0
`define CANTT_IE_FIFO1_NEW_FRAME_IRQ_EN 1
`define CANTT_IE_DEDICATED_BUF_IRQ_EN 2
`define CANTT_CCR_SRC_BIT 8
`define CANTT_RST_WORD 32'h0000_0000
`endif

// >>> rtl/cantt_pkg.sv
// Types shared by the CAN timer block
package cantt_pkg;
    typedef logic [15:0] cantt_cnt_t;
    typedef enum logic [1:0] {
        CANTT_IDLE = 2'b01,
        CANTT_RUN = 2'b10
    } cantt_tt_e;
    typedef struct packed {
        cantt_cnt_t rxto_reload;
        logic rxto_ie;
        logic rxto_flag;
        cantt_cnt_t rxto_cnt;
        cantt_cnt_t [2:0] tt_reload;
        cantt_cnt_t [2:0] tt_cnt;
        cantt_tt_e [2:0] tt_st;
        logic [2:0] tt_trig;
        logic [8:0] ccr;
        logic [7:0] pre_cnt;
        logic [2:0] irq_en;
        logic rx_irq;
        logic pready;
        logic [31:0] prdata;
        logic pslverr;
    } cantt_state_s;
endpackage : cantt_pkg

// >>> rtl/cantt_timers.sv
// CAN receive-timeout timer and three transmit trigger timers behind APB
//
// Contract
// - Receive timeout is enabled whenever its reload field is non-zero.
// - Timeout interrupt request is raised only with timeout interrupt enable set.
// - Timeout fires spuriously after stores whose new-frame interrupt enable is clear.
// - Each trigger timer register holds the reload count of its timer.
// - Shared clock-control register selects trigger timer source and prescaler.
// - Writing a reload with the run bit set starts the trigger timer.
// - Trigger timer counts one step past reload before triggering transmission.
// - Receive buffer writes only DLC bytes; other bytes keep old values.
`timescale 1ns/1ps
`default_nettype none
`include "cantt_params.svh"
module cantt_timers
    import cantt_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic i_ext_tick,
    input wire logic i_rx_store,
    input wire logic [1:0] i_rx_target,
    input wire logic [3:0] i_rx_dlc,
    output logic o_pready,
    output logic [31:0] o_prdata,
    output logic o_pslverr,
    output logic [2:0] o_tx_trigger,
    output logic o_rx_timeout_irq,
    output logic o_rx_new_irq,
    output logic [7:0] o_rx_byte_we
);
    cantt_state_s s_q;
    cantt_state_s s_d;
    logic wr_acc;
    logic rd_acc;
    logic tick;
    logic stored_en;
    logic [7:0] byte_we_q;
    logic [3:0] nbytes;
    logic rxto_expire;
    logic irq_q;

    assign wr_acc = i_psel && i_penable && i_pwrite && !s_q.pready;
    assign rd_acc = i_psel && i_penable && !i_pwrite && !s_q.pready;
    // Timer tick: source select and prescaler from the clock-control register
    assign tick = (s_q.ccr[`CANTT_CCR_SRC_BIT] ? i_ext_tick : 1'b1) && (s_q.pre_cnt == 8'h00);
    // Storage kinds whose new-frame interrupt is enabled restart the timeout
    assign stored_en = i_rx_store && s_q.irq_en[i_rx_target[1:0] == 2'd3 ? 2'd2 : i_rx_target];
    // Expiry: counter at one on a tick with no enabled store to restart it
    assign rxto_expire = (s_q.rxto_reload != 16'h0000) && !stored_en && tick
                         && (s_q.rxto_cnt == 16'h0001);

    // Next-state logic for bus slave and timers
    always_comb begin
        s_d = s_q;
        s_d.pready = 1'b0;
        s_d.pslverr = 1'b0;
        s_d.tt_trig = 3'b000;
        s_d.rx_irq = 1'b0;
        if (s_q.ccr[`CANTT_CCR_SRC_BIT] ? i_ext_tick : 1'b1) begin
            s_d.pre_cnt = (s_q.pre_cnt == 8'h00) ? s_q.ccr[7:0] : s_q.pre_cnt - 8'h01;
        end
        // Receive timeout counting
        if (s_q.rxto_reload != 16'h0000) begin
            if (stored_en) begin
                s_d.rxto_cnt = s_q.rxto_reload;
            end else if (tick && s_q.rxto_cnt != 16'h0000) begin
                s_d.rxto_cnt = s_q.rxto_cnt - 16'h0001;
                if (rxto_expire) begin
                    s_d.rxto_flag = 1'b1;
                    s_d.rxto_cnt = s_q.rxto_reload;
                end
            end
        end
        if (i_rx_store && s_q.irq_en[i_rx_target[1:0] == 2'd3 ? 2'd2 : i_rx_target]) begin
            s_d.rx_irq = 1'b1;
        end
        // Trigger timers count reload+1 ticks, then trigger
        for (int k = 0; k < 3; k++) begin
            unique case (s_q.tt_st[k])
                CANTT_IDLE: begin
                end
                CANTT_RUN: begin
                    if (tick) begin
                        if (s_q.tt_cnt[k] == s_q.tt_reload[k]) begin
                            s_d.tt_trig[k] = 1'b1;
                            s_d.tt_cnt[k] = 16'h0000;
                        end else begin
                            s_d.tt_cnt[k] = s_q.tt_cnt[k] + 16'h0001;
                        end
                    end
                end
                default: s_d.tt_st[k] = CANTT_IDLE;
            endcase
        end
        // Register writes
        if (wr_acc) begin
            s_d.pready = 1'b1;
            unique case (i_paddr)
                `CANTT_OFF_RXTO: begin
                    s_d.rxto_reload = i_pwdata[`CANTT_RELOAD_W-1:0];
                    s_d.rxto_cnt = i_pwdata[`CANTT_RELOAD_W-1:0];
                    s_d.rxto_ie = i_pwdata[`CANTT_TIMEOUT_IRQ_ENABLE_BIT];
                end
                `CANTT_OFF_TTA, `CANTT_OFF_TTB, `CANTT_OFF_TTC: begin
                    s_d.tt_reload[i_paddr[3:2] - 2'd1] = i_pwdata[`CANTT_RELOAD_W-1:0];
                    s_d.tt_cnt[i_paddr[3:2] - 2'd1] = 16'h0000;
                    s_d.tt_st[i_paddr[3:2] - 2'd1] = i_pwdata[`CANTT_RUN_BIT] ? CANTT_RUN : CANTT_IDLE;
                end
                `CANTT_OFF_CCR: s_d.ccr = i_pwdata[8:0];
                `CANTT_OFF_IE: s_d.irq_en = i_pwdata[2:0];
                `CANTT_OFF_STAT: begin
                    // Clear by writing one; a timeout in the same cycle wins
                    if (i_pwdata[`CANTT_TE_BIT] && !rxto_expire) begin
                        s_d.rxto_flag = 1'b0;
                    end
                end
                default: s_d.pslverr = 1'b1;
            endcase
        end
        // Register reads
        if (rd_acc) begin
            s_d.pready = 1'b1;
            s_d.prdata = `CANTT_RST_WORD;
            unique case (i_paddr)
                `CANTT_OFF_RXTO: s_d.prdata = {1'b0, s_q.rxto_ie, s_q.rxto_flag, 13'h0000, s_q.rxto_reload};
                `CANTT_OFF_TTA, `CANTT_OFF_TTB, `CANTT_OFF_TTC:
                    s_d.prdata = {s_q.tt_st[i_paddr[3:2] - 2'd1] == CANTT_RUN, 15'h0000,
                                  s_q.tt_reload[i_paddr[3:2] - 2'd1]};
                `CANTT_OFF_CCR: s_d.prdata = {23'h000000, s_q.ccr};
                `CANTT_OFF_IE: s_d.prdata = {29'h00000000, s_q.irq_en};
                `CANTT_OFF_STAT: s_d.prdata = {2'b00, s_q.rxto_flag, 26'h0000000, s_q.tt_st[2] == CANTT_RUN,
                                               s_q.tt_st[1] == CANTT_RUN, s_q.tt_st[0] == CANTT_RUN};
                default: s_d.pslverr = 1'b1;
            endcase
        end
    end

    // State register with synchronous reset
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            s_q <= '{rxto_reload: 16'h0000, rxto_ie: 1'b0, rxto_flag: 1'b0, rxto_cnt: 16'h0000,
                     tt_reload: '0, tt_cnt: '0, tt_st: '{CANTT_IDLE, CANTT_IDLE, CANTT_IDLE}, tt_trig: 3'b000,
                     ccr: 9'h000, pre_cnt: 8'h00, irq_en: 3'b000, rx_irq: 1'b0,
                     pready: 1'b0, prdata: 32'h0000_0000, pslverr: 1'b0};
            byte_we_q <= 8'h00;
            irq_q <= 1'b0;
        end else begin
            s_q <= s_d;
            // Interrupt level taken from the next state so the pin comes straight from a flop
            irq_q <= s_d.rxto_flag && s_d.rxto_ie;
            byte_we_q <= i_rx_store ? ((8'h01 << nbytes) - 8'h01) | {8{nbytes[3]}} : 8'h00;
        end
    end

    // Byte count from DLC, capped at eight data bytes
    assign nbytes = (i_rx_dlc > 4'd8) ? 4'd8 : i_rx_dlc;

    assign o_pready = s_q.pready;
    assign o_prdata = s_q.prdata;
    assign o_pslverr = s_q.pslverr;
    assign o_tx_trigger = s_q.tt_trig;
    assign o_rx_timeout_irq = irq_q;
    assign o_rx_new_irq = s_q.rx_irq;
    assign o_rx_byte_we = byte_we_q;

    // Checks on the timeout path, the trigger timers and the receive byte mask
    a_timeout_gated: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        o_rx_timeout_irq == (s_q.rxto_flag && s_q.rxto_ie)) else $error("timeout irq without enable");
    a_timeout_off: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (s_q.rxto_reload == 16'h0000 && !wr_acc) |=> $stable(s_q.rxto_flag) || !s_q.rxto_flag)
        else $error("timeout flag set while disabled");
    a_restart_reload: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (stored_en && s_q.rxto_reload != 16'h0000 && !wr_acc) |=> s_q.rxto_cnt == $past(s_q.rxto_reload))
        else $error("timeout not restarted");
    a_start_run: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (wr_acc && i_paddr == `CANTT_OFF_TTA && i_pwdata[`CANTT_RUN_BIT]) |=> s_q.tt_st[0] == CANTT_RUN)
        else $error("trigger timer not started");
    a_trig_at_reload: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        s_q.tt_trig[0] |-> $past(s_q.tt_cnt[0]) == $past(s_q.tt_reload[0]))
        else $error("trigger before reload+1 steps");
    a_reload_held: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        !wr_acc |=> $stable(s_q.tt_reload)) else $error("reload changed without write");
    a_prescale_gap: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (tick && !s_q.ccr[`CANTT_CCR_SRC_BIT] && s_q.ccr[7:0] == 8'h01 && !wr_acc) |=> !tick)
        else $error("prescaler ignored");
    a_byte_mask: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (i_rx_store && i_rx_dlc == 4'd2) |=> o_rx_byte_we == 8'h03) else $error("wrong byte mask");
    a_spurious: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (i_rx_store && !stored_en) |=> $stable(s_q.rx_irq) || !s_q.rx_irq)
        else $error("irq on masked store");

    // Expiry sets the flag and beats a clear in the same cycle; a lone clear empties it
    a_expire_flag: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        rxto_expire |=> s_q.rxto_flag) else $error("timeout flag not set on expiry");
    a_expire_reload: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (rxto_expire && !wr_acc) |=> s_q.rxto_cnt == $past(s_q.rxto_reload))
        else $error("timeout not reloaded on expiry");
    a_flag_clear: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (wr_acc && i_paddr == `CANTT_OFF_STAT && i_pwdata[`CANTT_TE_BIT] && !rxto_expire) |=> !s_q.rxto_flag)
        else $error("timeout flag not cleared");
    a_stop_run: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (wr_acc && i_paddr == `CANTT_OFF_TTA && !i_pwdata[`CANTT_RUN_BIT]) |=> s_q.tt_st[0] == CANTT_IDLE)
        else $error("trigger timer not stopped");
    a_ext_idle: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (s_q.ccr[`CANTT_CCR_SRC_BIT] && !i_ext_tick) |-> !tick) else $error("tick without external source");
    a_new_frame: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (i_rx_store && stored_en) |=> o_rx_new_irq) else $error("new frame irq missing");
    a_byte_mask_full: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (i_rx_store && i_rx_dlc > 4'd8) |=> o_rx_byte_we == 8'hff) else $error("long frame mask wrong");

    // Main scenarios to be reached
    c_timeout: cover property (@(posedge i_clk) o_rx_timeout_irq);
    c_trigger: cover property (@(posedge i_clk) |o_tx_trigger);
    c_store: cover property (@(posedge i_clk) i_rx_store && stored_en);
    c_set_wins: cover property (@(posedge i_clk) rxto_expire && wr_acc && i_paddr == `CANTT_OFF_STAT);
    c_ext_tick: cover property (@(posedge i_clk) tick && s_q.ccr[`CANTT_CCR_SRC_BIT]);
endmodule : cantt_timers
`default_nettype wire

// >>> testbench/cantt_rx_node.sv
// Far-side CAN node model: hands received frames to the block at a fixed spacing
`timescale 1ns/1ps
`default_nettype none
module cantt_rx_node (
    input wire logic i_clk,
    input wire logic i_en,
    output logic o_store = 1'b0,
    output logic [1:0] o_target = 2'h0,
    output logic [3:0] o_dlc = 4'h0
);
    logic [2:0] gap_q = 3'h0;
    // One frame every eight cycles; DLC and storage target step through all codes
    always_ff @(posedge i_clk) begin
        gap_q <= gap_q + 3'h1;
        o_store <= i_en && gap_q == 3'h7;
        if (o_store) begin
            o_dlc <= o_dlc + 4'h1;
            o_target <= o_target + 2'h1;
        end
    end
endmodule : cantt_rx_node
`default_nettype wire

// >>> testbench/cantt_timers_tb.sv
// Self-checking bench for the CAN timeout and trigger timer block
`timescale 1ns/1ps
`default_nettype none
module cantt_timers_tb;
    logic i_clk = 1'b0, i_rst_b = 1'b0, i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0, i_ext_tick = 1'b0;
    logic [11:0] i_paddr = 12'h000;
    logic [31:0] i_pwdata = 32'h0, rd, o_prdata;
    logic o_pready, o_pslverr, o_rx_timeout_irq, o_rx_new_irq, i_rx_store, node_en = 1'b0, er;
    logic [2:0] o_tx_trigger;
    logic [1:0] i_rx_target;
    logic [3:0] i_rx_dlc;
    logic [7:0] o_rx_byte_we, exp_we = 8'h00;
    int num_errors = 0, compares = 0, gap, new_cnt = 0, n0;
    // Register rows: address, write data, expected read data
    logic [11:0] ra[5] = '{12'h000, 12'h008, 12'h010, 12'h014, 12'h020};
    logic [31:0] rw[5] = '{32'h4000_0000, 32'h0000_0123, 32'h0000_0105, 32'h0000_0007, 32'hffff_ffff};
    logic [31:0] rx[5] = '{32'h4000_0000, 32'h0000_0123, 32'h0000_0105, 32'h0000_0007, 32'h0000_0000};
    cantt_timers dut (.i_clk, .i_rst_b, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .i_ext_tick,
        .i_rx_store, .i_rx_target, .i_rx_dlc, .o_pready, .o_prdata, .o_pslverr, .o_tx_trigger,
        .o_rx_timeout_irq, .o_rx_new_irq, .o_rx_byte_we);
    cantt_rx_node node (.i_clk(i_clk), .i_en(node_en), .o_store(i_rx_store), .o_target(i_rx_target),
        .o_dlc(i_rx_dlc));
    initial forever #2.5 i_clk = ~i_clk;
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic print_verdict;
        $display("compares %0d mismatches %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : print_verdict
    // APB transfer: setup, access, hold until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge i_clk);
        i_psel <= 1'b1;
        i_pwrite <= w;
        i_paddr <= a;
        i_pwdata <= d;
        @(posedge i_clk);
        i_penable <= 1'b1;
        @(posedge i_clk);
        while (o_pready !== 1'b1 && n < 50) begin
            @(posedge i_clk);
            n++;
        end
        if (n == 50) begin
            num_errors++;
            $display("[ERR] pready expected 1 seen %b", o_pready);
            print_verdict;
        end
        rd = o_prdata;
        er = o_pslverr;
        i_psel <= 1'b0;
        i_penable <= 1'b0;
    endtask : apb
    // Distance in cycles between two trigger pulses of timer k, 200 if none
    task automatic tgap(input int k);
        repeat (3) begin
            gap = 0;
            do begin
                @(posedge i_clk);
                gap++;
            end while (o_tx_trigger[k] !== 1'b1 && gap < 200);
        end
    endtask : tgap
    // Byte write mask follows the DLC of each store one cycle later
    always @(posedge i_clk) begin
        if (i_rst_b) begin
            chk("byte mask", o_rx_byte_we, exp_we);
        end
        if (i_rst_b && o_rx_new_irq === 1'b1) begin
            new_cnt <= new_cnt + 1;
        end
        exp_we <= (!i_rst_b || !i_rx_store) ? 8'h00 : i_rx_dlc > 4'h7 ? 8'hff : 8'((9'h1 << i_rx_dlc) - 9'h1);
    end
    initial begin
        #50000;
        num_errors++;
        $display("[ERR] watchdog expected finish seen timeout");
        print_verdict;
    end
    initial begin
        repeat (5) @(posedge i_clk);
        i_rst_b <= 1'b1;
        for (int a = 0; a < 7; a++) begin
            apb(1'b0, 12'(4 * a), 32'h0);
            chk("reset value", rd, 0);
        end
        for (int k = 0; k < 5; k++) begin
            apb(1'b1, ra[k], rw[k]);
            chk("slave error", er, ra[k] == 12'h020);
            apb(1'b0, ra[k], 32'h0);
            chk("read back", rd, rx[k]);
        end
        $display("register test done");
        apb(1'b1, 12'h010, 32'h0);
        for (int k = 0; k < 3; k++) begin
            apb(1'b1, 12'(4 + 4 * k), 32'h8000_0000 | 32'(k * 3 + 2));
            tgap(k);
            chk("trigger period", gap, 32'(k * 3 + 3));
            apb(1'b1, 12'(4 + 4 * k), 32'h0);
        end
        apb(1'b1, 12'h010, 32'h1);
        apb(1'b1, 12'h004, 32'h8000_0002);
        tgap(0);
        chk("prescaled period", gap, 6);
        apb(1'b1, 12'h010, 32'h100);
        tgap(0);
        chk("external idle", gap, 200);
        i_ext_tick <= 1'b1;
        tgap(0);
        chk("external period", gap, 3);
        apb(1'b1, 12'h004, 32'h0);
        apb(1'b1, 12'h010, 32'h0);
        $display("trigger test done");
        node_en <= 1'b1;
        apb(1'b1, 12'h014, 32'h7);
        apb(1'b1, 12'h000, 32'h4000_0014);
        n0 = new_cnt;
        repeat (100) @(posedge i_clk);
        chk("no timeout", o_rx_timeout_irq, 0);
        chk("new frame pulses", 32'((new_cnt - n0) >= 12 && (new_cnt - n0) <= 13), 1);
        apb(1'b1, 12'h014, 32'h0);
        repeat (2) @(posedge i_clk);
        n0 = new_cnt;
        repeat (58) @(posedge i_clk);
        chk("spurious timeout", o_rx_timeout_irq, 1);
        chk("masked new frame", new_cnt - n0, 0);
        apb(1'b1, 12'h000, 32'h0000_0014);
        repeat (2) @(posedge i_clk);
        chk("masked timeout", o_rx_timeout_irq, 0);
        node_en <= 1'b0;
        apb(1'b1, 12'h000, 32'h4000_0000);
        apb(1'b1, 12'h018, 32'h2000_0000);
        repeat (60) @(posedge i_clk);
        chk("disabled timeout", o_rx_timeout_irq, 0);
        apb(1'b1, 12'h000, 32'h4000_0014);
        repeat (60) @(posedge i_clk);
        chk("expiry", o_rx_timeout_irq, 1);
        apb(1'b0, 12'h000, 32'h0);
        chk("flag read", rd[29], 1);
        $display("timeout test done");
        i_rst_b <= 1'b0;
        repeat (2) @(posedge i_clk);
        chk("reset irq", o_rx_timeout_irq, 0);
        i_rst_b <= 1'b1;
        apb(1'b0, 12'h000, 32'h0);
        chk("reset reload", rd, 0);
        $display("reset test done");
        print_verdict;
    end
endmodule : cantt_timers_tb
`default_nettype wire
